// File: hdl/irq_pin_consts.svh
// constants for the interrupt, lock and probe pin logic
`ifndef IRQ_PIN_CONSTS_SVH
`define IRQ_PIN_CONSTS_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_VECTOR 8'h0c

// control fields
`define CTRL_IRQ_EN 0
`define CTRL_LIC_EN 1
`define CTRL_PROBE_RDY 2
`define CTRL_RESET 3'h2

// command fields, write only pulses
`define CMD_BOUNDARY 0
`define CMD_RETURN 1
`define CMD_LOCK_BEGIN 2
`define CMD_LOCK_END 3

// fixed nonmaskable vector
`define NMI_VECTOR 8'h02

`endif

// File: hdl/irq_pin_pkg.sv
// types shared by the interrupt, lock and probe pin logic
package irq_pin_pkg;

   // maskable dispatch state
   typedef enum logic [1:0]
   {
      ack_idle = 2'b00,
      ack_wait = 2'b01
   } ack_state_e;

   typedef logic [7:0] vector_t;

endpackage

// File: hdl/pin_sync.sv
// two flop synchroniser with edge detection for asynchronous pins
`timescale 1ns/1ns
module pin_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // asynchronous pins
   input wire logic [W-1:0] pin_i,
   // synchronised view
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);

   logic [W-1:0] meta_reg; // first stage, read only by second
   logic [W-1:0] sync_reg; // settled level
   logic [W-1:0] prev_reg; // previous settled level for edges

   // synchroniser chain plus history flop
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
         prev_reg <= RESET_VAL;
      end
      else
      begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edges only from settled stages
   assign level_o = sync_reg;
   assign rise_o = sync_reg & ~prev_reg;
   assign fall_o = ~sync_reg & prev_reg;

endmodule

// File: hdl/nmi_tracker.sv
// nonmaskable interrupt pending and in-service bookkeeping
`timescale 1ns/1ns
module nmi_tracker
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // synchronous hold from pin reset or supply loss
   input wire logic hold_i,
   // events
   input wire logic edge_i,
   input wire logic take_i,
   input wire logic return_i,
   // state
   output logic pending_o,
   output logic in_service_o
);

   logic pending_reg; // one assertion held
   logic service_reg; // handler running

   // pending flag, set wins over the clear of a dispatch
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         pending_reg <= 1'b0;
      else if (hold_i)
         pending_reg <= 1'b0;
      else if (edge_i)
         pending_reg <= 1'b1;
      else if (take_i)
         pending_reg <= 1'b0;
   end

   // handler in service until the return
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         service_reg <= 1'b0;
      else if (hold_i)
         service_reg <= 1'b0;
      else if (take_i)
         service_reg <= 1'b1;
      else if (return_i)
         service_reg <= 1'b0;
   end

   assign pending_o = pending_reg;
   assign in_service_o = service_reg;

endmodule

// File: hdl/irq_pin_logic.sv
// processor-side interrupt pins, bus lock, probe and reset qualification
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`include "irq_pin_consts.svh"
module irq_pin_logic
   import irq_pin_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // asynchronous interrupt and system pins
   input wire logic [1:0] local_irq_pins_i,
   input wire logic reset_pin_n_i,
   input wire logic supply_stable_in_i,
   input wire logic probe_request_n_i,
   output logic probe_ready_n_o,
   // interrupt bus, clock and open drain data
   input wire logic irq_bus_clock_i,
   input wire logic [1:0] irq_bus_data_i,
   output logic [1:0] irq_bus_data_o,
   output logic [1:0] irq_bus_data_oe_o,
   // system bus unit, same clock
   output logic irq_ack_cycle_o,
   input wire logic ack_done_i,
   input wire logic [7:0] ack_vector_i,
   input wire logic txn_start_i,
   input wire logic txn_end_i,
   output logic bus_lock_o,
   // dispatch to the core
   output logic dispatch_o,
   output logic [7:0] dispatch_vector_o
);

   // synchronised pin views
   logic [1:0] pins_lvl; // local pins, settled
   logic [1:0] pins_rise; // local pin rising edges
   logic rstn_lvl; // pin reset, active low
   logic rstn_rise; // pin reset release
   logic pwr_lvl; // supply stable level
   logic probe_request_n_n_lvl; // probe request, active low
   logic iclk_rise; // interrupt bus clock rising edge
   logic [1:0] idat_lvl; // interrupt bus data lines

   // all local pins pass two flops before use
   pin_sync #(.W(2), .RESET_VAL(2'h0)) u_pins
   (
      .clk_i(clk_i), .rst_i(rst_i), .pin_i(local_irq_pins_i),
      .level_o(pins_lvl), .rise_o(pins_rise), .fall_o()
   );

   // pin reset starts active so the core stays quiet
   pin_sync #(.W(1), .RESET_VAL(1'h0)) u_rstn
   (
      .clk_i(clk_i), .rst_i(rst_i), .pin_i(reset_pin_n_i),
      .level_o(rstn_lvl), .rise_o(rstn_rise), .fall_o()
   );

   // supply stable, relied on to be glitch free
   pin_sync #(.W(1), .RESET_VAL(1'h0)) u_pwr
   (
      .clk_i(clk_i), .rst_i(rst_i), .pin_i(supply_stable_in_i),
      .level_o(pwr_lvl), .rise_o(), .fall_o()
   );

   // probe request, idle high
   pin_sync #(.W(1), .RESET_VAL(1'h1)) u_probe_request_n
   (
      .clk_i(clk_i), .rst_i(rst_i), .pin_i(probe_request_n_i),
      .level_o(probe_request_n_n_lvl), .rise_o(), .fall_o()
   );

   // interrupt bus clock is sampled, not used as a clock
   pin_sync #(.W(1), .RESET_VAL(1'h0)) u_iclk
   (
      .clk_i(clk_i), .rst_i(rst_i), .pin_i(irq_bus_clock_i),
      .level_o(), .rise_o(iclk_rise), .fall_o()
   );

   // interrupt bus data, pulled up when idle
   pin_sync #(.W(2), .RESET_VAL(2'h3)) u_idat
   (
      .clk_i(clk_i), .rst_i(rst_i), .pin_i(irq_bus_data_i),
      .level_o(idat_lvl), .rise_o(), .fall_o()
   );

   // core held while pin reset active or supply not stable
   logic hold; // synchronous clear for dispatch, acknowledge, lock and nonmaskable state; ctrl_reg kept
   assign hold = ~rstn_lvl | ~pwr_lvl;

   // register and bus handshake state
   logic [2:0] ctrl_reg; // enable flag, controller enable, probe ready
   logic bus_ack_reg; // one wait state, then answer
   logic wr_go; // write takes effect this edge
   logic [3:0] cmd; // command pulses

   assign wr_go = write & bus_ack_reg & byteenable[0];
   assign cmd = (wr_go && address == `REG_CMD) ? writedata[3:0] : 4'h0;

   // decoder used for reads and writes alike
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   // controller enable strap caught at pin reset release
   logic lic_off_reg; // controller disabled in hardware
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         lic_off_reg <= 1'b0;
      else if (rstn_rise)
         lic_off_reg <= ~idat_lvl[0];
   end

   // local mode only when enabled in hardware and software
   logic lic_on; // pins in local interrupt mode
   logic mask_src; // maskable request source
   logic nmi_edge; // nonmaskable rising edge
   assign lic_on = ~lic_off_reg & ctrl_reg[`CTRL_LIC_EN];
   assign mask_src = ~lic_on & pins_lvl[0];
   assign nmi_edge = ~lic_on & pins_rise[1];

   // control register; reset value puts pins in local mode
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl_reg <= `CTRL_RESET;
      else if (wr_go && hit(address, `REG_CTRL))
         ctrl_reg <= writedata[2:0];
   end

   // maskable dispatch state
   ack_state_e state_reg; // acknowledge in flight or not
   logic nmi_pend; // one nonmaskable waiting
   logic nmi_serv; // nonmaskable handler running
   logic take_nmi; // dispatch nonmaskable now
   logic take_mask; // start acknowledge now
   logic boundary; // instruction boundary from software

   assign boundary = cmd[`CMD_BOUNDARY] & ~hold;
   // nonmaskable first; none while its own handler runs
   // held off while an acknowledge is in flight so its answer is kept
   assign take_nmi = boundary & nmi_pend & ~nmi_serv
      & (state_reg == ack_idle);
   // maskable needs the flag and no acknowledge in flight
   assign take_mask = boundary & ~take_nmi & mask_src
      & ctrl_reg[`CTRL_IRQ_EN] & (state_reg == ack_idle);

   nmi_tracker u_nmi
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .hold_i(hold),
      .edge_i(nmi_edge),
      .take_i(take_nmi),
      .return_i(cmd[`CMD_RETURN]),
      .pending_o(nmi_pend),
      .in_service_o(nmi_serv)
   );

   // one acknowledge cycle per accepted request
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_reg <= ack_idle;
      else if (hold)
         state_reg <= ack_idle;
      else
         unique case (state_reg)
            ack_idle:
               if (take_mask)
                  state_reg <= ack_wait;
            ack_wait:
               if (ack_done_i)
                  state_reg <= ack_idle;
            default:
               state_reg <= ack_idle;
         endcase
   end

   // acknowledge only for maskable, dropped under reset
   assign irq_ack_cycle_o = (state_reg == ack_wait) & ~hold;

   // dispatch pulse and vector to the core
   logic disp_reg; // one cycle dispatch strobe
   logic [7:0] vec_reg; // last vector dispatched
   logic vec_nmi_reg; // last dispatch was nonmaskable
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         disp_reg <= 1'b0;
         vec_reg <= 8'h00;
         vec_nmi_reg <= 1'b0;
      end
      else if (hold)
         disp_reg <= 1'b0;
      else if (take_nmi)
      begin
         disp_reg <= 1'b1;
         vec_reg <= `NMI_VECTOR;
         vec_nmi_reg <= 1'b1;
      end
      else if (state_reg == ack_wait && ack_done_i)
      begin
         disp_reg <= 1'b1;
         vec_reg <= ack_vector_i;
         vec_nmi_reg <= 1'b0;
      end
      else
         disp_reg <= 1'b0;
   end
   assign dispatch_o = disp_reg;
   assign dispatch_vector_o = vec_reg;

   // lock: armed by software, follows transaction edges
   logic lock_want_reg; // next transaction opens the sequence
   logic lock_reg; // lock driven on the bus
   logic lock_rel_reg; // next transaction end closes it
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         lock_want_reg <= 1'b0;
      else if (hold)
         lock_want_reg <= 1'b0;
      else if (cmd[`CMD_LOCK_BEGIN])
         lock_want_reg <= 1'b1;
      else if (txn_start_i)
         lock_want_reg <= 1'b0;
   end

   // release request, kept until the closing transaction ends
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         lock_rel_reg <= 1'b0;
      else if (hold)
         lock_rel_reg <= 1'b0;
      else if (cmd[`CMD_LOCK_END])
         lock_rel_reg <= 1'b1;
      else if (txn_end_i)
         lock_rel_reg <= 1'b0; // stale release never outlives a txn
   end

   // start of first to end of last transaction
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         lock_reg <= 1'b0;
      else if (hold)
         lock_reg <= 1'b0;
      else if (txn_start_i && lock_want_reg)
         lock_reg <= 1'b1;
      else if (txn_end_i && lock_rel_reg && !cmd[`CMD_LOCK_END])
         lock_reg <= 1'b0;
   end
   // priority agents wait on this level before taking the bus
   assign bus_lock_o = lock_reg & ~hold;

   // probe ready follows software readiness, active low
   logic probe_ready_n_n_reg; // registered probe ready pin
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         probe_ready_n_n_reg <= 1'b1;
      else
         probe_ready_n_n_reg <= ~(ctrl_reg[`CTRL_PROBE_RDY] & ~hold);
   end
   assign probe_ready_n_o = probe_ready_n_n_reg;

   // interrupt bus: sampled on its own clock edges only
   logic [1:0] idat_reg; // data captured at bus clock rise
   logic [7:0] iclk_cnt_reg; // bus clock rising edges seen
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         idat_reg <= 2'h3;
         iclk_cnt_reg <= 8'h00;
      end
      else if (iclk_rise)
      begin
         idat_reg <= idat_lvl;
         iclk_cnt_reg <= iclk_cnt_reg + 8'h01;
      end
   end
   // message protocol not carried here, so lines never pulled
   assign irq_bus_data_o = 2'h0;
   assign irq_bus_data_oe_o = 2'h0;

   // status word assembled from live state
   logic [31:0] status; // read-only view
   assign status = {8'h00, iclk_cnt_reg, 4'h0, idat_reg, pins_lvl,
      pwr_lvl, ~probe_request_n_n_lvl, lic_off_reg, lic_on, lock_reg,
      (state_reg == ack_wait), nmi_serv, nmi_pend};

   // one wait state for every access
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         bus_ack_reg <= 1'b0;
      else
         bus_ack_reg <= (read | write) & ~bus_ack_reg;
   end
   assign waitrequest = (read | write) & ~bus_ack_reg;

   // read data loaded in the wait cycle; unmapped read zero
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         readdata <= 32'h0;
      else if (read && !bus_ack_reg)
      begin
         if (hit(address, `REG_CTRL))
            readdata <= {29'h0, ctrl_reg};
         else if (hit(address, `REG_STATUS))
            readdata <= status;
         else if (hit(address, `REG_VECTOR))
            readdata <= {23'h0, vec_nmi_reg, vec_reg};
         else
            readdata <= 32'h0; // command and unmapped
      end
   end

endmodule

// File: tb/irq_pin_logic_assertions.sv
// checker for bus timing, acknowledge, lock and dispatch relations
`timescale 1ns/1ns
module irq_pin_logic_checker
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   // system pins
   input wire logic reset_pin_n_i,
   input wire logic supply_stable_in_i,
   // interrupt bus lines
   input wire logic [1:0] irq_bus_data_o,
   input wire logic [1:0] irq_bus_data_oe_o,
   // system bus unit
   input wire logic irq_ack_cycle_o,
   input wire logic ack_done_i,
   input wire logic [7:0] ack_vector_i,
   input wire logic txn_start_i,
   input wire logic txn_end_i,
   input wire logic bus_lock_o,
   // core dispatch
   input wire logic dispatch_o,
   input wire logic [7:0] dispatch_vector_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // no request sees more than one wait state
   property p_wait;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("wait state wrong");
   // acknowledge answer turns into one dispatch with its vector
   property p_ack_disp;
      irq_ack_cycle_o && ack_done_i
         |=> dispatch_o && dispatch_vector_o == $past(ack_vector_i);
   endproperty
   a_ack_disp: assert property (p_ack_disp) else $error("bad vector");
   // a single acknowledge per request
   property p_ack_once;
      irq_ack_cycle_o && ack_done_i |=> !irq_ack_cycle_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack stuck");
   // request stands until answered while pins stay good
   property p_ack_hold;
      irq_ack_cycle_o && !ack_done_i && reset_pin_n_i && supply_stable_in_i
         |=> irq_ack_cycle_o;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped");
   // dispatch with no acknowledge behind it carries vector two
   property p_fixed_vec;
      dispatch_o && !$past(ack_done_i) |-> dispatch_vector_o == 8'h02;
   endproperty
   a_fixed_vec: assert property (p_fixed_vec) else $error("vector");
   // pin reset releases bus outputs quickly
   property p_release;
      $fell(reset_pin_n_i) |-> ##[0:4] (!bus_lock_o && !irq_ack_cycle_o);
   endproperty
   a_release: assert property (p_release) else $error("no release");
   // open drain: never drive a line high
   property p_open_drain;
      (irq_bus_data_o & irq_bus_data_oe_o) == 2'b00;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("drives");
   // lock only begins with a transaction start
   property p_lock_rise;
      $rose(bus_lock_o) |-> $past(txn_start_i);
   endproperty
   a_lock_rise: assert property (p_lock_rise) else $error("lock early");
   // lock never drops before a transaction end while pins stay good
   property p_lock_hold;
      bus_lock_o && !txn_end_i && reset_pin_n_i && supply_stable_in_i
         |=> bus_lock_o;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock lost");
   // main scenarios reached
   c_ack: cover property (irq_ack_cycle_o && ack_done_i);
   c_fixed: cover property (dispatch_o && dispatch_vector_o == 8'h02);
   c_lock: cover property ($rose(bus_lock_o));
endmodule

bind irq_pin_logic irq_pin_logic_checker i_irq_pin_logic_checker
(
   .clk_i(clk_i), .rst_i(rst_i), .read(read), .write(write),
   .waitrequest(waitrequest), .reset_pin_n_i(reset_pin_n_i),
   .supply_stable_in_i(supply_stable_in_i),
   .irq_bus_data_o(irq_bus_data_o), .irq_bus_data_oe_o(irq_bus_data_oe_o),
   .irq_ack_cycle_o(irq_ack_cycle_o), .ack_done_i(ack_done_i),
   .ack_vector_i(ack_vector_i), .txn_start_i(txn_start_i),
   .txn_end_i(txn_end_i), .bus_lock_o(bus_lock_o),
   .dispatch_o(dispatch_o), .dispatch_vector_o(dispatch_vector_o)
);

// File: tb/chipset_model.sv
// chipset side: acknowledge responder, bus clock, pulled-up data lines
`timescale 1ns/1ns
module chipset_model
(
   // clock
   input wire logic clk_i,
   // acknowledge request and settings
   input wire logic ack_req_i,
   input wire logic [2:0] ack_delay_i,
   input wire logic [7:0] vec_i,
   input wire logic strap_i,
   // answers
   output logic ack_done_o,
   output logic [7:0] ack_vector_o,
   output logic irq_bus_clock_o,
   output logic [1:0] irq_bus_data_o
);
   logic [2:0] cnt_reg = 3'h0; // cycles waited on a request
   // free running bus clock, 80 ns, offset from the core clock
   initial
   begin
      irq_bus_clock_o = 1'b0;
      #7;
      forever #40 irq_bus_clock_o = ~irq_bus_clock_o;
   end
   // released lines sit at the pull-up; only the strap pulls line zero
   assign irq_bus_data_o = {1'b1, strap_i};
   // answer each acknowledge after the chosen delay
   initial
   begin
      ack_done_o = 1'b0;
      ack_vector_o = 8'h5a;
   end
   always @(posedge clk_i)
   begin
      if (ack_req_i && !ack_done_o && cnt_reg == ack_delay_i)
      begin
         ack_done_o <= 1'b1;
         ack_vector_o <= vec_i;
         cnt_reg <= 3'h0;
      end
      else
      begin
         ack_done_o <= 1'b0;
         // vector churns outside an answer so stale data cannot pass
         ack_vector_o <= ~ack_vector_o;
         cnt_reg <= (ack_req_i && !ack_done_o) ? cnt_reg + 3'h1 : 3'h0;
      end
   end
endmodule

// File: tb/irq_pin_logic_tb_top.sv
// self-checking bench for the interrupt, lock and probe pin logic
`timescale 1ns/1ns
`include "irq_pin_consts.svh"
module irq_pin_logic_tb_top;
   import irq_pin_pkg::*;
   // design side signals; those the bench drives are given a value at time zero, the outputs are not
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [7:0] address = 8'h00;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [1:0] pins = 2'b00;
   logic rpin_n = 1'b0;
   logic supply = 1'b0;
   logic probe_request_n_n = 1'b1;
   logic ts = 1'b0;
   logic te = 1'b0;
   logic strap = 1'b0;
   logic [7:0] vec = 8'h00;
   logic [2:0] dly = 3'h0;
   logic [31:0] readdata;
   logic waitrequest, probe_ready_n_n, bclk, ack_req, ack_done, lock, disp;
   logic [1:0] bd_i, bd_o, bd_oe;
   logic [7:0] ack_vec, dvec;
   // bench state
   logic [31:0] seed = 32'hd930;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [31:0] rd_q[$];
   logic [31:0] mk_q[$];
   vector_t d_q[$];

   irq_pin_logic i_irq_pin_logic
   (
      .clk_i(clk_i), .rst_i(rst_i), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest),
      .local_irq_pins_i(pins), .reset_pin_n_i(rpin_n),
      .supply_stable_in_i(supply), .probe_request_n_i(probe_request_n_n),
      .probe_ready_n_o(probe_ready_n_n), .irq_bus_clock_i(bclk),
      .irq_bus_data_i(bd_i), .irq_bus_data_o(bd_o),
      .irq_bus_data_oe_o(bd_oe), .irq_ack_cycle_o(ack_req),
      .ack_done_i(ack_done), .ack_vector_i(ack_vec), .txn_start_i(ts),
      .txn_end_i(te), .bus_lock_o(lock), .dispatch_o(disp),
      .dispatch_vector_o(dvec)
   );
   chipset_model i_chipset_model
   (
      .clk_i(clk_i), .ack_req_i(ack_req), .ack_delay_i(dly), .vec_i(vec),
      .strap_i(strap), .ack_done_o(ack_done), .ack_vector_o(ack_vec),
      .irq_bus_clock_o(bclk), .irq_bus_data_o(bd_i)
   );

   // core clock, 100 MHz
   initial
   begin
      forever #5 clk_i = ~clk_i;
   end
   // compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // one avalon transfer held until waitrequest is seen low
   task automatic xfer(input logic rd, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be);
      @(posedge clk_i);
      read <= rd;
      write <= !rd;
      address <= a;
      writedata <= d;
      byteenable <= be;
      // waitrequest looked at on rising edges only
      @(posedge clk_i);
      while (waitrequest !== 1'b0)
         @(posedge clk_i);
      read <= 1'b0;
      write <= 1'b0;
   endtask
   // read with expectation noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
      rd_q.push_back(e);
      mk_q.push_back(m);
      xfer(1'b1, a, 32'h0, 4'hf);
   endtask
   task automatic cmd(input int b);
      xfer(1'b0, `REG_CMD, 32'h1 << b, 4'hf);
   endtask
   task automatic txn(input logic s);
      @(posedge clk_i);
      ts <= s;
      te <= !s;
      @(posedge clk_i);
      ts <= 1'b0;
      te <= 1'b0;
   endtask
   // maskable request, optionally racing a nonmaskable edge
   task automatic irq(input logic with_nmi);
      logic [31:0] r;
      r = rnd();
      vec <= r[7:0];
      dly <= r[10:8];
      pins <= {with_nmi, 1'b1};
      if (with_nmi)
      begin
         d_q.push_back(8'h02);
         cyc_wait(4);
         cmd(`CMD_BOUNDARY);
      end
      d_q.push_back(r[7:0]);
      cyc_wait(4);
      cmd(`CMD_BOUNDARY);
      @(negedge clk_i);
      while (ack_req === 1'b1)
         @(negedge clk_i);
      @(posedge clk_i);
      pins <= 2'b00; // source holds until answered
      @(posedge clk_i);
   endtask
   // monitor: oldest note against each read answer and each dispatch
   always @(posedge clk_i)
   begin
      if (read === 1'b1 && waitrequest === 1'b0)
         check(readdata & mk_q.pop_front(), rd_q.pop_front());
      if (disp === 1'b1)
         check(dvec, d_q.size() ? d_q.pop_front() : 8'hxx);
   end
   // hang guard
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         finish_test();
      end
   end

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      supply <= 1'b1; // rises cleanly once
      cyc_wait(20); // reset pulse shortened, design counts nothing
      rpin_n <= 1'b1; // strap still low
      cyc_wait(4);
      strap <= 1'b1;
      cyc_wait(30);
      rd(`REG_CTRL, 32'h2, 32'hffffffff);
      rd(`REG_STATUS, 32'hc20, 32'hc30);
      rd(8'h10, 32'h0, 32'hffffffff);
      // locked sequence across an inner transaction end
      cmd(`CMD_LOCK_BEGIN);
      txn(1'b1);
      txn(1'b0);
      cyc_wait(2);
      check(lock, 1'b1);
      txn(1'b1);
      cmd(`CMD_LOCK_END);
      check(lock, 1'b1);
      txn(1'b0);
      cyc_wait(2);
      check(lock, 1'b0); // bus free for a priority agent
      // pin reset in mid lock
      cmd(`CMD_LOCK_BEGIN);
      txn(1'b1);
      rpin_n <= 1'b0;
      cyc_wait(5);
      check(lock, 1'b0);
      rpin_n <= 1'b1;
      cyc_wait(10);
      cmd(`CMD_LOCK_END);
      txn(1'b0);
      rd(`REG_STATUS, 32'hc10, 32'hc30);
      // probe handshake and a refused byte lane
      probe_request_n_n <= 1'b0;
      xfer(1'b0, `REG_CTRL, 32'h6, 4'hf);
      xfer(1'b0, `REG_CTRL, 32'h0, 4'he);
      cyc_wait(3);
      check(probe_ready_n_n, 1'b0);
      rd(`REG_STATUS, 32'h40, 32'h40);
      rd(`REG_CTRL, 32'h6, 32'h7);
      // local mode on: pin one edge must be ignored
      pins <= 2'b10;
      cyc_wait(5);
      pins <= 2'b00;
      cmd(`CMD_BOUNDARY);
      // pins mode, flag clear: no acknowledge
      xfer(1'b0, `REG_CTRL, 32'h0, 4'hf);
      pins <= 2'b01;
      cyc_wait(4);
      cmd(`CMD_BOUNDARY);
      cyc_wait(8);
      check(ack_req, 1'b0);
      xfer(1'b0, `REG_CTRL, 32'h1, 4'hf);
      repeat (3) irq(1'b0);
      // nonmaskable: dispatch, then two edges while in service
      pins <= 2'b10;
      d_q.push_back(8'h02);
      cyc_wait(5);
      cmd(`CMD_BOUNDARY);
      rd(`REG_VECTOR, 32'h102, 32'h1ff);
      repeat (2)
      begin
         pins <= 2'b00;
         cyc_wait(3);
         pins <= 2'b10;
         cyc_wait(4);
      end
      cmd(`CMD_BOUNDARY); // held while in service
      cyc_wait(6);
      d_q.push_back(8'h02);
      cmd(`CMD_RETURN);
      cmd(`CMD_BOUNDARY);
      cmd(`CMD_RETURN);
      cmd(`CMD_BOUNDARY); // one kept, level ignored
      cyc_wait(6);
      pins <= 2'b00;
      cyc_wait(4);
      irq(1'b1);
      cmd(`CMD_RETURN);
      // supply loss and return
      supply <= 1'b0;
      cyc_wait(4);
      rd(`REG_STATUS, 32'h0, 32'h80);
      supply <= 1'b1;
      cyc_wait(6);
      rd(`REG_STATUS, 32'h80, 32'h80);
      cyc_wait(20);
      check(d_q.size(), 32'h0);
      finish_test();
   end
endmodule
